// ---- hw/adcsr_pkg.sv ----
// Behaviour
// - Strobe rise samples serial_in: high picks select mode, low picks chain.
// - Select mode enables busy if strobe or serial_in low at conversion end.
// - 3-wire busy: output floats after 19th shift fall or strobe rise.
// - Each output bit stays valid across both shift-clock edges.
// - 4-wire, serial_in high: strobe rise converts, selects, floats output.
// - 4-wire: host keeps strobe high; both low drives output low outside conversion.
// - 4-wire no busy: serial_in fall shows MSB; shift falls shift on.
// - 4-wire no busy: float after 16th fall or serial_in rise.
// - Select busy: output goes from float to low at conversion end.
// - After conversion the converter idles until next strobe rise.
// - 4-wire busy: MSB first; float after 19th fall or serial_in rise.
// - Chain mode: serial_in and strobe both low drive output low, except during conversion.
// - Strobe rise with shift clock low: chain mode, busy disabled.
// - Chain without busy: MSB appears at conversion end.
// - Chain: serial_in shifts into register on each shift-clock fall, except the first fall after busy (busy bit).
// - Strobe rise with shift clock high: chain mode, busy enabled.
// - Chain busy: output goes high at conversion end.
package adcsr_pkg;
  localparam int          DATA_W        = 16;
  localparam int          BUSY_LAST     = 19;
  localparam int          PLAIN_LAST    = 16;
  localparam int          CLK_MHZ       = 200;
  localparam int          TCONV_MIN_NS  = 500;
  localparam int          TCONV_MAX_NS  = 1600;
  localparam int          CONV_MIN_CYC  = (TCONV_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          CONV_MAX_CYC  = (TCONV_MAX_NS * CLK_MHZ) / 1000;
  localparam logic [15:0] SAMPLE_RESET  = 16'h0000;

  typedef enum logic [3:0] {
    ADCSR_IDLE = 4'h1,
    ADCSR_CONV = 4'h2,
    ADCSR_READ = 4'h4,
    ADCSR_DONE = 4'h8
  } adcsr_state_t;
endpackage

// ---- hw/adcsr_buf_if.sv ----
`timescale 1ns/1ps
interface adcsr_buf_if #(parameter int W = 16);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport buf_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ---- hw/adcsr_buf.sv ----
`timescale 1ns/1ps
module adcsr_buf
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  adcsr_buf_if.buf_side  bus
);
  // ------------------------------------------------------------
  // Two-entry buffer
  // ------------------------------------------------------------
  logic [$bits(bus.in_data)-1:0] mem [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;

  assign bus.in_ready  = (count != 2'h2);
  assign bus.out_valid = (count != 2'h0);
  assign bus.out_data  = mem[rd_ptr];

  always_ff @(posedge clk_i)
  begin
    if (bus.in_valid && bus.in_ready)
    begin
      mem[wr_ptr] <= bus.in_data;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (bus.in_valid && bus.in_ready)
      begin
        wr_ptr <= ~wr_ptr;
      end
      if (bus.out_valid && bus.out_ready)
      begin
        rd_ptr <= ~rd_ptr;
      end
      count <= 2'(count + 2'((bus.in_valid && bus.in_ready) ? 1 : 0)
                        - 2'((bus.out_valid && bus.out_ready) ? 1 : 0));
    end
  end
endmodule

// ---- hw/adcsr_core.sv ----
`timescale 1ns/1ps
module adcsr_core
  import adcsr_pkg::*;
#(
  parameter int CONV_MIN = adcsr_pkg::CONV_MIN_CYC,
  parameter int CONV_MAX = adcsr_pkg::CONV_MAX_CYC
)
(
  input  wire logic                    CLK_I,
  input  wire logic                    SYS_RST_I,
  input  wire logic                    CONVERSION_STROBE_I,
  input  wire logic                    SHIFT_CLK_I,
  input  wire logic                    SERIAL_IN_I,
  input  wire logic [adcsr_pkg::DATA_W-1:0] SAMPLE_DATA_I,
  input  wire logic                    SAMPLE_VALID_I,
  output logic                         SAMPLE_READY_O,
  output logic                         SERIAL_OUT_O,
  output logic                         SERIAL_OUT_OE_O,
  output logic                         CONVERTING_O,
  output logic                         POWERED_DOWN_O
);
  import adcsr_pkg::*;

  if (CONV_MIN < 1 || CONV_MAX < CONV_MIN)
  begin : g_conv_range
    $error("conversion time parameters out of range");
  end

  // ------------------------------------------------------------
  // Pin synchronisers: three stages, change counts on 2nd == 3rd
  // ------------------------------------------------------------
  logic [2:0] cnv_s, sck_s, sdi_s;
  logic       conversion_strobe, sck, serial_in, cnv_q, sck_q, sdi_q;

  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      cnv_s <= 3'h0;
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
      conversion_strobe   <= 1'b0;
      sck   <= 1'b0;
      serial_in   <= 1'b0;
      cnv_q <= 1'b0;
      sck_q <= 1'b0;
      sdi_q <= 1'b0;
    end
    else
    begin
      cnv_s <= {cnv_s[1:0], CONVERSION_STROBE_I};
      sck_s <= {sck_s[1:0], SHIFT_CLK_I};
      sdi_s <= {sdi_s[1:0], SERIAL_IN_I};
      if (cnv_s[1] == cnv_s[2]) conversion_strobe <= cnv_s[2];
      if (sck_s[1] == sck_s[2]) sck <= sck_s[2];
      if (sdi_s[1] == sdi_s[2]) serial_in <= sdi_s[2];
      cnv_q <= conversion_strobe;
      sck_q <= sck;
      sdi_q <= serial_in;
    end
  end

  logic cnv_rise, sck_fall, sdi_rise, sdi_fall;
  assign cnv_rise = conversion_strobe & ~cnv_q;
  assign sck_fall = ~sck & sck_q;
  assign sdi_rise = serial_in & ~sdi_q;
  assign sdi_fall = ~serial_in & sdi_q;

  // ------------------------------------------------------------
  // Sample buffer between the converter core and the shifter
  // ------------------------------------------------------------
  adcsr_buf_if #(.W(DATA_W)) sbuf ();

  assign sbuf.in_valid  = SAMPLE_VALID_I;
  assign sbuf.in_data   = SAMPLE_DATA_I;
  assign SAMPLE_READY_O = sbuf.in_ready;

  adcsr_buf u_buf
  (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .bus   (sbuf)
  );

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  adcsr_state_t state;
  logic         chain_mode;
  logic         busy_en;
  logic [31:0]  conv_cnt;
  logic         conv_end;
  logic [DATA_W-1:0] shreg;
  logic [5:0]   falls;
  logic         drive;
  logic         dout;
  logic         announce;

  // Conversion only ends once a word is available; a stalled sample
  // source stretches the conversion instead of losing the word.
  assign conv_end        = (state == ADCSR_CONV) && (conv_cnt >= 32'(CONV_MAX - 1))
                           && sbuf.out_valid;
  assign sbuf.out_ready  = conv_end;
  assign CONVERTING_O    = (state == ADCSR_CONV);
  assign POWERED_DOWN_O  = (state != ADCSR_CONV);

  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state      <= ADCSR_IDLE;
      chain_mode <= 1'b0;
      busy_en    <= 1'b0;
      conv_cnt   <= 32'h0;
    end
    else if (cnv_rise)
    begin
      state      <= ADCSR_CONV;
      chain_mode <= ~serial_in;
      busy_en    <= ~serial_in & sck;
      conv_cnt   <= 32'h0;
    end
    else
    begin
      case (state)
        ADCSR_IDLE: state <= ADCSR_IDLE;
        ADCSR_CONV:
        begin
          conv_cnt <= conv_cnt + 32'h1;
          if (conv_end)
          begin
            state <= ADCSR_READ;
            if (!chain_mode)
              busy_en <= ~conversion_strobe | ~serial_in;
          end
        end
        ADCSR_READ:
          if (!drive && falls != 6'h0)
            state <= ADCSR_DONE;
        ADCSR_DONE: state <= ADCSR_DONE;
        default:    state <= ADCSR_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Shift register and output driver
  // ------------------------------------------------------------
  logic [5:0] last_fall;
  assign last_fall = busy_en ? 6'(BUSY_LAST) : 6'(PLAIN_LAST);

  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      shreg    <= SAMPLE_RESET;
      falls    <= 6'h0;
      drive    <= 1'b0;
      dout     <= 1'b0;
      announce <= 1'b0;
    end
    else if (cnv_rise)
    begin
      drive    <= 1'b0;
      falls    <= 6'h0;
      announce <= 1'b0;
    end
    else if (conv_end)
    begin
      shreg <= sbuf.out_data;
      if (chain_mode)
      begin
        drive    <= 1'b1;
        // Busy choice was latched at the strobe rise; the shift clock may have moved since
        announce <= busy_en;
        dout     <= busy_en ? 1'b1 : sbuf.out_data[DATA_W-1];
      end
      else if (~conversion_strobe | ~serial_in)
      begin
        drive    <= 1'b1;
        announce <= 1'b1;
        dout     <= 1'b0;
      end
    end
    else if (state == ADCSR_READ)
    begin
      if (chain_mode)
      begin
        if (sck_fall)
        begin
          // Busy start bit occupies the first fall, then the word shifts.
          if (announce)
          begin
            announce <= 1'b0;
            dout     <= shreg[DATA_W-1];
          end
          else
          begin
            shreg <= {shreg[DATA_W-2:0], serial_in};
            dout  <= shreg[DATA_W-2];
          end
        end
      end
      else
      begin
        if (!drive && !announce && falls == 6'h0 && (~conversion_strobe | sdi_fall))
        begin
          drive <= 1'b1;
          dout  <= shreg[DATA_W-1];
        end
        else if (drive && sdi_rise && conversion_strobe)
        begin
          drive <= 1'b0;
          falls <= 6'h1;
        end
        else if (drive && sck_fall)
        begin
          falls <= 6'(falls + 6'h1);
          if (announce)
          begin
            announce <= 1'b0;
            dout     <= shreg[DATA_W-1];
          end
          else
          begin
            shreg <= {shreg[DATA_W-2:0], 1'b0};
            dout  <= shreg[DATA_W-2];
          end
          if (6'(falls + 6'h1) >= last_fall)
            drive <= 1'b0;
        end
      end
    end
  end

  logic force_low;
  assign force_low = ~serial_in & ~conversion_strobe && state != ADCSR_CONV;
  assign SERIAL_OUT_OE_O = drive | force_low;
  // Both pins low wins over a data bit that chain mode still holds
  assign SERIAL_OUT_O    = (drive & ~force_low) ? dout : 1'b0;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  mode_pick_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    cnv_rise |=> chain_mode == !$past(serial_in))
    else $error("mode not taken from serial_in");

  float_on_start_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    cnv_rise |=> !drive)
    else $error("output driven after strobe rise");

  busy_low_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    conv_end && !chain_mode && (!conversion_strobe || !serial_in) |=> SERIAL_OUT_OE_O && !SERIAL_OUT_O)
    else $error("busy edge missing");

  chain_busy_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    conv_end && chain_mode && busy_en |=> SERIAL_OUT_OE_O && SERIAL_OUT_O)
    else $error("chain busy not high");

  float_count_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    drive && !chain_mode && !busy_en && sck_fall && falls == 6'd15 |=> !drive)
    else $error("no float after sixteenth fall");

  float_busy_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    drive && !chain_mode && busy_en && sck_fall && falls == 6'd18 |=> !drive)
    else $error("no float after nineteenth fall");

  force_low_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !serial_in && !conversion_strobe && state != ADCSR_CONV |-> SERIAL_OUT_OE_O && !SERIAL_OUT_O)
    else $error("output not low with strobe and serial_in low");

  conv_len_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    conv_end |-> conv_cnt >= 32'(CONV_MAX - 1))
    else $error("conversion ended early");

  idle_after_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    conv_end |=> POWERED_DOWN_O)
    else $error("not powered down after conversion");

  start_float_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    cnv_rise |=> !SERIAL_OUT_OE_O)
    else $error("pin still driven after strobe rise");

  chain_msb_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    conv_end && chain_mode && !busy_en && conversion_strobe
    |=> SERIAL_OUT_OE_O && SERIAL_OUT_O == $past(sbuf.out_data[DATA_W-1]))
    else $error("chain msb not shown at conversion end");

  sel_release_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    state == ADCSR_READ && !chain_mode && drive && sdi_rise && conversion_strobe |=> !drive)
    else $error("no float on serial_in rise");

  chain_shift_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    state == ADCSR_READ && chain_mode && sck_fall && !announce && !cnv_rise
    |=> shreg[0] == $past(serial_in))
    else $error("serial_in not shifted in");

  msb_show_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    state == ADCSR_READ && !chain_mode && !drive && !announce && falls == 6'h0
    && sdi_fall && !cnv_rise |=> drive && dout == shreg[DATA_W-1])
    else $error("msb not shown on serial_in fall");

  chain_cov_c:  cover property (@(posedge CLK_I) conv_end && chain_mode && !busy_en);
  chainb_cov_c: cover property (@(posedge CLK_I) conv_end && chain_mode && busy_en);
  sel_cov_c:    cover property (@(posedge CLK_I) drive && !chain_mode && falls == 6'd15);
  selb_cov_c:   cover property (@(posedge CLK_I) drive && !chain_mode && falls == 6'd18);
  sel3b_cov_c:  cover property (@(posedge CLK_I) conv_end && !chain_mode && !conversion_strobe && serial_in);
endmodule

// ---- tb/adcsr_host.sv ----
`timescale 1ns/1ps
module adcsr_host
(
  input  wire logic clk_i,
  input  wire logic sout_i,
  input  wire logic oe_i,
  output logic      strobe_o,
  output logic      sck_o,
  output logic      sdi_o,
  output logic      line_o
);
  // ----------
  // Shared line
  // ----------
  // External pull-up holds the line high while nobody drives it
  assign line_o = oe_i ? sout_i : 1'b1;

  initial
  begin
    strobe_o = 1'b0;
    sck_o    = 1'b0;
    sdi_o    = 1'b0;
  end

  task automatic pins(input logic s, input logic k, input logic d);
    @(posedge clk_i);
    #1;
    strobe_o = s;
    sck_o    = k;
    sdi_o    = d;
  endtask

  // Shift clock only runs inside frames, phase free of clk_i
  task automatic pulses(input int n, input logic [31:0] feed, output logic [31:0] cap);
    cap = '0;
    for (int i = 0; i < n; i++)
    begin
      sdi_o = feed[31-i];
      sck_o = 1'b1;
      #62.5;
      cap   = {cap[30:0], line_o};
      sck_o = 1'b0;
      #62.5;
    end
  endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import adcsr_pkg::*;
  localparam int          CMIN = 2;
  localparam int          CMAX = 8;
  localparam logic [15:0] W0   = 16'hb5a3;
  localparam logic [15:0] W1   = 16'h6c19;
  localparam logic [15:0] W2   = 16'h93e4;
  localparam logic [15:0] W3   = 16'h2a7d;
  localparam logic [15:0] W4   = 16'h58f0;
  localparam logic [15:0] W5   = 16'h4d2b;
  localparam logic [15:0] UP   = 16'he1c6;
  logic              clk    = 1'b0;
  logic              rst    = 1'b1;
  logic [DATA_W-1:0] sdata  = '0;
  logic              svalid = 1'b0;
  logic              sready, sout, soe, conv, pdown, strobe, sck, serial_in, line;
  logic [31:0]       cap;
  int                miscompares     = 0;
  int                samples_checked = 0;

  always #2.5 clk = ~clk;

  adcsr_host host (.clk_i(clk), .sout_i(sout), .oe_i(soe), .strobe_o(strobe),
                   .sck_o(sck), .sdi_o(serial_in), .line_o(line));

  adcsr_core #(.CONV_MIN(CMIN), .CONV_MAX(CMAX)) dut (
    .CLK_I(clk), .SYS_RST_I(rst), .CONVERSION_STROBE_I(strobe), .SHIFT_CLK_I(sck),
    .SERIAL_IN_I(serial_in), .SAMPLE_DATA_I(sdata), .SAMPLE_VALID_I(svalid),
    .SAMPLE_READY_O(sready), .SERIAL_OUT_O(sout), .SERIAL_OUT_OE_O(soe),
    .CONVERTING_O(conv), .POWERED_DOWN_O(pdown));

  // ----------
  // Helpers
  // ----------
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic give_up();
    miscompares++;
    report_and_stop();
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic push(input logic [15:0] w);
    int i;
    cyc(1);
    sdata  = w;
    svalid = 1'b1;
    for (i = 0; i < 50 && sready !== 1'b1; i++)
      cyc(1);
    if (i == 50)
      give_up();
    cyc(1);
    svalid = 1'b0;
  endtask

  task automatic start(input logic d, input logic k);
    host.pins(1'b0, k, d);
    cyc(4);
    host.pins(1'b1, k, d);
  endtask

  // Waits out the longest conversion before any readback
  task automatic wait_done();
    int i;
    cyc(8);
    for (i = 0; i < 100 && conv !== 1'b0; i++)
      cyc(1);
    if (i == 100)
      give_up();
    cyc(3);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic sc_buffer();
    push(W0);
    push(W1);
    check("ready when full", sready, 1'b0);
  endtask

  task automatic sc_sel3();
    start(1'b1, 1'b0);
    cyc(6);
    check("float on start", soe, 1'b0);
    wait_done();
    check("idle after conversion", pdown, 1'b1);
    check("ready after drain", sready, 1'b1);
    host.pins(1'b0, 1'b0, 1'b1);
    cyc(8);
    check("msb select", line, W0[15]);
    check("msb drive", soe, 1'b1);
    host.pulses(16, '1, cap);
    check("select word", cap[15:0], W0);
    cyc(8);
    check("float after 16", soe, 1'b0);
  endtask

  task automatic sc_sel4_busy();
    start(1'b1, 1'b0);
    host.pins(1'b1, 1'b0, 1'b0);
    wait_done();
    check("busy drive", soe, 1'b1);
    check("busy low", line, 1'b0);
    host.pulses(19, '0, cap);
    check("busy word", cap[18:2], {1'b0, W1});
    cyc(8);
    check("float after 19", soe, 1'b0);
  endtask

  task automatic sc_sel4_abort();
    push(W2);
    start(1'b1, 1'b0);
    wait_done();
    check("float no busy", soe, 1'b0);
    host.pins(1'b1, 1'b0, 1'b0);
    cyc(8);
    check("msb on select", line, W2[15]);
    check("msb on drive", soe, 1'b1);
    host.pulses(4, '0, cap);
    check("partial word", cap[3:0], W2[15:12]);
    host.pins(1'b1, 1'b0, 1'b1);
    cyc(8);
    check("float on release", soe, 1'b0);
  endtask

  task automatic sc_chain();
    push(W3);
    host.pins(1'b0, 1'b0, 1'b0);
    cyc(8);
    check("idle drive", soe, 1'b1);
    check("idle low", line, 1'b0);
    start(1'b0, 1'b0);
    wait_done();
    check("chain msb", line, W3[15]);
    host.pulses(32, {UP, 16'h0000}, cap);
    check("chain words", cap, {W3, UP});
  endtask

  task automatic sc_chain_busy();
    push(W4);
    start(1'b0, 1'b1);
    wait_done();
    check("chain busy drive", soe, 1'b1);
    check("chain busy high", line, 1'b1);
    host.pulses(17, '0, cap);
    check("chain busy word", cap[16:0], {1'b1, W4});
  endtask

  // 3-wire with busy: strobe drops early, a strobe rise cuts the readback
  task automatic sc_sel3_busy();
    push(W5);
    start(1'b1, 1'b0);
    cyc(1);
    host.pins(1'b0, 1'b0, 1'b1);
    wait_done();
    check("busy3 drive", soe, 1'b1);
    check("busy3 low", line, 1'b0);
    host.pulses(3, '1, cap);
    check("busy3 head", cap[2:0], {1'b0, W5[15:14]});
    host.pins(1'b1, 1'b0, 1'b1);
    cyc(8);
    check("busy3 cut", soe, 1'b0);
  endtask

  initial
  begin
    cyc(4);
    // Both pins low in reset: the device already drives the line low
    check("oe in reset", soe, 1'b1);
    check("low in reset", line, 1'b0);
    check("ready in reset", sready, 1'b1);
    rst = 1'b0;
    cyc(4);
    sc_buffer();
    sc_sel3();
    sc_sel4_busy();
    sc_sel4_abort();
    sc_chain();
    sc_chain_busy();
    sc_sel3_busy();
    report_and_stop();
  end
endmodule
